// File: hw/rcd_pkg.sv
// Constants for the read clock, decoder and mark detector block
package rcd_pkg;
	localparam int CLK_NS      = 5;       // Core clock period
	localparam int HOLD_NS     = 200;     // Oscillator hold window
	localparam int LOCK_NS     = 2000;    // Data_lock_window interval
	localparam int STROBE_PS   = 2900;    // Strobe shift, one cycle at least
	localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOCK_CYC    = (LOCK_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC  = (STROBE_PS + CLK_NS * 1000 - 1) / (CLK_NS * 1000);
	localparam int PD_FIX_CYC  = 4;       // Fixed pump-down length
	localparam int SYNC_ZEROS  = 3;       // Zeros ahead of the sync one
	localparam int AM_MIN      = 20;      // Shortest mark gap, half-rate periods
	localparam int AM_MAX      = 36;      // Longest mark gap, half-rate periods
	localparam int SEQ_W       = 8;       // One-hot sequencer width
	localparam int NRZ_LAG     = 2;       // Steps from a coded pair to its NRZ bit
	// Sequencer states, one flip-flop each
	localparam int ST_START    = 0;       // Word boundary
	localparam int ST_P10      = 1;       // Seen 10
	localparam int ST_P00      = 2;       // Seen 00
	localparam int ST_P0010    = 3;       // Seen 00 10
	localparam int ST_P0000    = 4;       // Seen 00 00
	localparam int ST_T2       = 5;       // Tail of two-pair word
	localparam int ST_T3       = 6;       // Tail of three-pair word
	localparam int ST_T4       = 7;       // Tail of four-pair word
	// Coded pairs
	localparam logic [1:0] PR_00 = 2'h0;
	localparam logic [1:0] PR_01 = 2'h1;
	localparam logic [1:0] PR_10 = 2'h2;
	// Decoded data words, first bit highest
	localparam logic [3:0] DW_X0 = 4'h2;  // Ends in 0 after a 1: 10, 010, 0010
	localparam logic [3:0] DW_X1 = 4'h3;  // Ends in 11: 11, 011, 0011
	localparam logic [3:0] DW_Z  = 4'h0;  // 000
	localparam logic [2:0] LEN2  = 3'h2;
	localparam logic [2:0] LEN3  = 3'h3;
	localparam logic [2:0] LEN4  = 3'h4;
endpackage : rcd_pkg

// File: hw/rcd_core.sv
// Read oscillator control, strobe shift, 2,7 decoder and mark detector
`timescale 1ns/10ps
module rcd_core
(
	input  wire logic core_clk,             // 200 MHz clock
	input  wire logic rst_n,                // Async reset, active low
	input  wire logic read_gate,            // Read gate, active high
	input  wire logic mark_search_enable,   // Address mark search enable
	input  wire logic latched_read_pulse,   // Latched read pulse
	input  wire logic write_reference_osc,  // Write reference oscillator
	input  wire logic write_half_osc,       // Write-derived half-rate clock
	input  wire logic double_rate_read_osc, // Double-rate read oscillator
	input  wire logic clocked_read_data,    // Coded data from discriminator
	input  wire logic strobe_early,         // Early strobe select
	input  wire logic strobe_late,          // Late strobe select
	output logic      pump_up,              // Pump-up pulse
	output logic      pump_down,            // Pump-down pulse
	output logic      osc_hold_window,      // Oscillator stop/start
	output logic      data_lock_window,     // Data_lock_window
	output logic      half_rate_clk,        // Half-rate read clock
	output logic      nrz_data,             // Decoded NRZ data
	output logic      mark_found,           // Address mark found
	output logic      address_mark_status   // Interface status line
);
	import rcd_pkg::*;

	typedef struct packed {
		logic                wref_q;
		logic                dro_q;
		logic                lrp_q;
		logic                whalf_q;
		logic                rg_q;
		logic                dro_rise_d;
		logic                data_d;
		logic                pu;
		logic                pd;
		logic [3:0]          pd_cnt;
		logic                armed;
		logic                hold;
		logic [5:0]          hold_cnt;
		logic                lock;
		logic [8:0]          lock_cnt;
		logic                synced;
		logic [1:0]          zeros;
		logic                half;
		logic                prev_bit;
		logic [SEQ_W-1:0]    seq;
		logic [7:0]          q;
		logic [3:0]          qcnt;
		logic [1:0]          lag;
		logic                nrz;
		logic [5:0]          am_cnt;
		logic                am_found;
		logic                am_status;
	} rcd_state_type;

	rcd_state_type s_reg;
	rcd_state_type s_next;
	logic          rst_meta_reg;
	logic          rst_sync_reg;

	// Reset release through two flops, assertion stays asynchronous
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_reg <= 1'h0;
			rst_sync_reg <= 1'h0;
		end
		else
		begin
			rst_meta_reg <= 1'h1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Edge events from the sampled levels
	logic wref_rise;
	logic dro_rise;
	logic lrp_rise;
	logic whalf_rise;
	logic coin_mode;
	logic am_enable;
	assign wref_rise  = write_reference_osc && !s_reg.wref_q;
	assign dro_rise   = double_rate_read_osc && !s_reg.dro_q;
	assign lrp_rise   = latched_read_pulse && !s_reg.lrp_q;
	assign whalf_rise = write_half_osc && !s_reg.whalf_q;
	assign coin_mode  = !read_gate || mark_search_enable;
	assign am_enable  = read_gate && mark_search_enable;

	always_comb
	begin
		logic       samp_ev;
		logic       samp_bit;
		logic       step;
		logic [1:0] pair;
		logic [2:0] wlen;
		logic [3:0] wbits;
		logic [7:0] tmp;
		logic [3:0] cnt;
		samp_ev  = 1'h0;
		samp_bit = 1'h0;
		step     = 1'h0;
		pair     = PR_00;
		wlen     = 3'h0;
		wbits    = DW_Z;
		tmp      = 8'h00;
		cnt      = 4'h0;
		s_next   = s_reg;
		s_next.wref_q     = write_reference_osc;
		s_next.dro_q      = double_rate_read_osc;
		s_next.lrp_q      = latched_read_pulse;
		s_next.whalf_q    = write_half_osc;
		s_next.rg_q       = read_gate;
		s_next.dro_rise_d = dro_rise;
		s_next.data_d     = clocked_read_data;

		// Hold window: armed by any gate change, fired by the next pulse
		if (s_reg.hold_cnt != 6'h00)
			s_next.hold_cnt = s_reg.hold_cnt - 6'h01;
		if (s_reg.armed && lrp_rise)
		begin
			s_next.armed    = 1'h0;
			s_next.hold_cnt = 6'(HOLD_CYC);
		end
		// A gate change in the firing cycle re-arms, so it is never lost
		if (read_gate != s_reg.rg_q)
			s_next.armed = 1'h1;
		s_next.hold = (s_next.hold_cnt != 6'h00);

		// Phase comparators; pumps are idle while the oscillator is held
		if (s_next.hold)
		begin
			s_next.pu     = 1'h0;
			s_next.pd     = 1'h0;
			s_next.pd_cnt = 4'h0;
		end
		else if (coin_mode)
		begin
			// Coincidence: whichever edge comes first opens its pump
			s_next.pd_cnt = 4'h0;
			if (wref_rise && !dro_rise)
			begin
				if (s_reg.pd)
					s_next.pd = 1'h0;
				else
					s_next.pu = 1'h1;
			end
			else if (dro_rise && !wref_rise)
			begin
				if (s_reg.pu)
					s_next.pu = 1'h0;
				else
					s_next.pd = 1'h1;
			end
		end
		else
		begin
			// Quadrature: variable up until the oscillator edge, fixed down
			if (s_reg.pd_cnt != 4'h0)
				s_next.pd_cnt = s_reg.pd_cnt - 4'h1;
			if (lrp_rise)
				s_next.pu = 1'h1;
			else if (s_reg.pu && dro_rise)
			begin
				s_next.pu     = 1'h0;
				s_next.pd_cnt = 4'(PD_FIX_CYC);
			end
			s_next.pd = (s_next.pd_cnt != 4'h0);
		end

		// Lock window drops after a full interval of reading without search
		if (read_gate && !mark_search_enable)
		begin
			if (s_reg.lock_cnt != 9'(LOCK_CYC))
				s_next.lock_cnt = s_reg.lock_cnt + 9'h001;
			s_next.lock = (s_next.lock_cnt != 9'(LOCK_CYC));
		end
		else
		begin
			s_next.lock_cnt = 9'h000;
			s_next.lock     = 1'h1;
		end

		// Strobe shift; sub-cycle delay rounds up to one clock
		samp_ev  = strobe_early ? s_reg.dro_rise_d : dro_rise;
		samp_bit = strobe_late ? s_reg.data_d : clocked_read_data;
		// With nominal timing the data is sampled at the clock edge
		// mid-pulse, so no further alignment is applied here.

		// Synchronizer and gated divide-by-two; the next lock value clears the
		// divider in the same cycle the window rises
		if (s_next.lock)
		begin
			s_next.synced = 1'h0;
			s_next.lag    = 2'h0;
			s_next.zeros  = 2'h0;
			s_next.half   = 1'h0;
			s_next.seq    = SEQ_W'(1) << ST_START;
			s_next.qcnt   = 4'h0;
			s_next.nrz    = 1'h0;
		end
		else if (samp_ev)
		begin
			s_next.prev_bit = samp_bit;
			if (!s_reg.synced)
			begin
				if (samp_bit && s_reg.zeros == 2'(SYNC_ZEROS))
				begin
					s_next.synced = 1'h1;
					s_next.half   = 1'h1;
				end
				else if (samp_bit)
					s_next.zeros = 2'h0;
				else if (s_reg.zeros != 2'(SYNC_ZEROS))
					s_next.zeros = s_reg.zeros + 2'h1;
			end
			else
			begin
				s_next.half = !s_reg.half;
				step        = s_reg.half;
			end
		end

		// Sequencer step on each falling half-rate edge, one NRZ bit each after the first NRZ_LAG steps
		pair = {s_reg.prev_bit, samp_bit};
		if (step)
		begin
			s_next.seq = SEQ_W'(1) << ST_START;
			if (s_reg.seq[ST_START])
			begin
				if (pair == PR_01)
				begin
					s_next.seq = SEQ_W'(1) << ST_T2;
					wbits      = DW_X0;
					wlen       = LEN2;
				end
				else if (pair == PR_10)
					s_next.seq = SEQ_W'(1) << ST_P10;
				else if (pair == PR_00)
					s_next.seq = SEQ_W'(1) << ST_P00;
			end
			else if (s_reg.seq[ST_P10])
			begin
				if (pair == PR_00)
				begin
					wbits = DW_X1;
					wlen  = LEN2;
				end
				else if (pair == PR_01)
				begin
					s_next.seq = SEQ_W'(1) << ST_T3;
					wbits      = DW_X0;
					wlen       = LEN3;
				end
			end
			else if (s_reg.seq[ST_P00])
			begin
				if (pair == PR_01)
				begin
					s_next.seq = SEQ_W'(1) << ST_T3;
					wbits      = DW_Z;
					wlen       = LEN3;
				end
				else if (pair == PR_10)
					s_next.seq = SEQ_W'(1) << ST_P0010;
				else if (pair == PR_00)
					s_next.seq = SEQ_W'(1) << ST_P0000;
			end
			else if (s_reg.seq[ST_P0010])
			begin
				if (pair == PR_00)
				begin
					wbits = DW_X1;
					wlen  = LEN3;
				end
				else if (pair == PR_01)
				begin
					s_next.seq = SEQ_W'(1) << ST_T4;
					wbits      = DW_X0;
					wlen       = LEN4;
				end
			end
			else if (s_reg.seq[ST_P0000] && pair == PR_10)
			begin
				s_next.seq = SEQ_W'(1) << ST_T4;
				wbits      = DW_X1;
				wlen       = LEN4;
			end
			// Tail states only swallow the closing 00 pair
			// Words enter a small queue; bits leave one per step once NRZ_LAG
			// steps after sync have passed, since every word is known by then
			// and the queue can never run dry
			tmp = (s_reg.q << wlen) | {4'h0, wbits};
			cnt = s_reg.qcnt + {1'h0, wlen};
			if (s_reg.lag != 2'(NRZ_LAG))
				s_next.lag = s_reg.lag + 2'h1;
			else if (cnt != 4'h0)
			begin
				s_next.nrz = tmp[3'(cnt - 4'h1)];
				cnt        = cnt - 4'h1;
			end
			s_next.q    = tmp;
			s_next.qcnt = cnt;
		end

		// Mark detector: gap counter cleared by every read pulse
		if (!am_enable)
			s_next.am_cnt = 6'h00;
		else if (lrp_rise)
		begin
			// Gaps past the window are defects and never flag a mark
			if (s_reg.am_cnt >= 6'(AM_MIN) && s_reg.am_cnt <= 6'(AM_MAX))
				s_next.am_found = 1'h1;
			s_next.am_cnt = 6'h00;
		end
		else if (whalf_rise && s_reg.am_cnt != 6'(AM_MAX + 1))
			s_next.am_cnt = s_reg.am_cnt + 6'h01;
		// Clear at the end of the lock interval or when the gate drops
		if (!read_gate || (s_reg.lock && !s_next.lock))
			s_next.am_found = 1'h0;
		s_next.am_status = s_reg.am_found;
	end

	always_ff @(posedge core_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			s_reg      <= '0;
			s_reg.lock <= 1'h1;
			s_reg.seq  <= SEQ_W'(1) << ST_START;
		end
		else
			s_reg <= s_next;
	end

	assign pump_up             = s_reg.pu;
	assign pump_down           = s_reg.pd;
	assign osc_hold_window     = s_reg.hold;
	assign data_lock_window    = s_reg.lock;
	assign half_rate_clk       = s_reg.half;
	assign nrz_data            = s_reg.nrz;
	assign mark_found          = s_reg.am_found;
	assign address_mark_status = s_reg.am_status;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_reg);

	hold_start_a: assert property (s_reg.armed && lrp_rise |=> osc_hold_window)
		else $error("hold window did not open");
	hold_pump_a: assert property (osc_hold_window |-> !pump_up && !pump_down)
		else $error("pump active during hold");
	coin_up_a: assert property (coin_mode && wref_rise && !dro_rise && !s_reg.pd
		&& s_next.hold_cnt == 6'h00 |=> pump_up)
		else $error("leading reference gave no pump-up");
	coin_down_a: assert property (coin_mode && dro_rise && !wref_rise && !s_reg.pu
		&& s_next.hold_cnt == 6'h00 |=> pump_down)
		else $error("lagging reference gave no pump-down");
	quad_up_a: assert property (!coin_mode && lrp_rise && s_next.hold_cnt == 6'h00
		|=> pump_up)
		else $error("read pulse gave no pump-up");
	lock_drop_a: assert property ($fell(data_lock_window)
		|-> $past(s_reg.lock_cnt) == 9'(LOCK_CYC - 1))
		else $error("lock window fell at wrong time");
	nrz_low_a: assert property (data_lock_window |-> !nrz_data && !half_rate_clk)
		else $error("output active before sync");
	onehot_seq_a: assert property ($onehot(s_reg.seq))
		else $error("sequencer not one-hot");
	am_enable_a: assert property ($rose(mark_found)
		|-> $past(read_gate) && $past(mark_search_enable))
		else $error("mark found outside search");
	am_clear_a: assert property (!read_gate |=> !mark_found)
		else $error("mark found outlived read gate");
	am_status_a: assert property (mark_found |=> address_mark_status)
		else $error("status line missed mark found");

	hold_seen_c: cover property ($rose(osc_hold_window));
	sync_seen_c: cover property ($rose(s_reg.synced));
	nrz_one_c: cover property (nrz_data);
	mark_seen_c: cover property ($rose(mark_found));
endmodule : rcd_core

// File: sim/rcd_ctrl_model.sv
// Disk controller model driving read gate and control select lines
`timescale 1ns/10ps
module rcd_ctrl_model
(
	input  wire logic       core_clk,           // Block clock
	input  wire logic       rst_n,              // Reset, active low
	input  wire logic       tag_valid,          // Control select strobe
	input  wire logic [9:0] tag_bus,            // Bus bits of the command
	input  wire logic       gate_req,           // Read gate wanted
	output logic            read_gate,          // Read gate line
	output logic            mark_search_enable, // Mark search line
	output logic            strobe_early,       // Early strobe line
	output logic            strobe_late         // Late strobe line
);
	logic [9:0] bus_reg; // Last control select word

	// Quiet lines from time zero
	initial
	begin
		read_gate = 1'b0;
		mark_search_enable = 1'b0;
		strobe_early = 1'b0;
		strobe_late = 1'b0;
	end

	// Command capture at the sampling edge
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			bus_reg <= 10'h000;
		else if (tag_valid)
			bus_reg <= tag_bus;
	end

	// Lines move at the falling edge, clear of the block's sampling
	always @(negedge core_clk)
	begin
		read_gate <= gate_req & rst_n;
		mark_search_enable <= bus_reg[1] & bus_reg[5];
		strobe_early <= bus_reg[7];
		strobe_late <= bus_reg[8];
	end
endmodule : rcd_ctrl_model

// File: sim/tb.sv
// Self-checking bench for the read clock, decoder and mark detector
`timescale 1ns/10ps
`define CHK(got, exp, what) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("FAIL %0t %s", $time, what); \
		end \
	end
module tb;
	import rcd_pkg::*;
	logic core_clk, rst_n, tag_valid, gate_req;
	logic [9:0] tag_bus;
	logic rd_pulse, wr_ref, wr_half, rd_osc, rd_data;
	logic read_gate, mark_search_enable, strobe_early, strobe_late;
	logic pump_up, pump_down, osc_hold_window, data_lock_window;
	logic half_rate_clk, nrz_data, mark_found, address_mark_status;
	int fails, compares, cycles;

	rcd_ctrl_model ctrl (.core_clk(core_clk), .rst_n(rst_n), .tag_valid(tag_valid),
		.tag_bus(tag_bus), .gate_req(gate_req), .read_gate(read_gate),
		.mark_search_enable(mark_search_enable), .strobe_early(strobe_early),
		.strobe_late(strobe_late));
	rcd_core DUT (.core_clk(core_clk), .rst_n(rst_n), .read_gate(read_gate),
		.mark_search_enable(mark_search_enable), .latched_read_pulse(rd_pulse),
		.write_reference_osc(wr_ref), .write_half_osc(wr_half),
		.double_rate_read_osc(rd_osc), .clocked_read_data(rd_data),
		.strobe_early(strobe_early), .strobe_late(strobe_late), .pump_up(pump_up),
		.pump_down(pump_down), .osc_hold_window(osc_hold_window),
		.data_lock_window(data_lock_window), .half_rate_clk(half_rate_clk),
		.nrz_data(nrz_data), .mark_found(mark_found),
		.address_mark_status(address_mark_status));

	// 200 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Hang guard, well above the expected run of under two thousand cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			fails++;
			results();
		end
	end

	task results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	// One rising edge on an input: 0 ref, 1 read osc, 2 half-rate, 3 read pulse
	task pulse(input int w);
		case (w)
			0: wr_ref = 1'b1;
			1: rd_osc = 1'b1;
			2: wr_half = 1'b1;
			default: rd_pulse = 1'b1;
		endcase
		cyc(2);
		{wr_ref, rd_osc, wr_half, rd_pulse} = 4'h0;
		cyc(2);
	endtask : pulse

	task tag(input logic [9:0] b);
		tag_bus = b;
		tag_valid = 1'b1;
		cyc(1);
		tag_valid = 1'b0;
		cyc(3);
	endtask : tag

	// Data held around the clock edge so a one-cycle strobe shift still lands
	task code_bit(input logic b);
		rd_data = b;
		cyc(2);
		rd_osc = 1'b1;
		cyc(2);
		rd_osc = 1'b0;
		cyc(1);
	endtask : code_bit

	// Gap of n half-rate periods closed by a read pulse
	task gap(input int n);
		repeat (n) pulse(2);
		pulse(3);
	endtask : gap

	task t_coinc();
		pulse(0);
		`CHK(pump_up, 1'b1, "reference lead gives pump up")
		pulse(1);
		`CHK(pump_up, 1'b0, "pump up ends at read osc")
		pulse(1);
		`CHK(pump_down, 1'b1, "reference lag gives pump down")
		pulse(0);
		`CHK(pump_down, 1'b0, "pump down ends at reference")
	endtask : t_coinc

	task t_lock_hold();
		int n;
		int bad;
		gate_req = 1'b1;
		n = 0;
		while (data_lock_window === 1'b1 && n < 600)
		begin
			cyc(1);
			n++;
		end
		`CHK(n inside {[LOCK_CYC - 3:LOCK_CYC + 6]}, 1'b1, "lock window length")
		rd_pulse = 1'b1;
		n = 0;
		while (osc_hold_window !== 1'b1 && n < 4)
		begin
			cyc(1);
			n++;
		end
		`CHK(osc_hold_window, 1'b1, "hold after first pulse")
		n = 0;
		bad = 0;
		while (osc_hold_window === 1'b1 && n < 80)
		begin
			wr_ref = n[1];
			rd_osc = n[2];
			bad += int'(pump_up | pump_down);
			cyc(1);
			n++;
		end
		`CHK(n, HOLD_CYC, "hold window length")
		`CHK(bad, 0, "pumps still during hold")
		{wr_ref, rd_osc, rd_pulse} = 3'h0;
		cyc(4);
	endtask : t_lock_hold

	task t_quad();
		int n;
		pulse(1);
		rd_pulse = 1'b1;
		cyc(3);
		`CHK(pump_up, 1'b1, "read pulse gives pump up")
		rd_pulse = 1'b0;
		rd_osc = 1'b1;
		n = 0;
		while (pump_down !== 1'b1 && n < 4)
		begin
			cyc(1);
			n++;
		end
		`CHK(pump_up, 1'b0, "pump up ends at read osc")
		n = 0;
		while (pump_down === 1'b1 && n < 20)
		begin
			cyc(1);
			n++;
		end
		`CHK(n, PD_FIX_CYC, "fixed pump down length")
		rd_osc = 1'b0;
		cyc(2);
	endtask : t_quad

	task t_sync();
		`CHK(half_rate_clk, 1'b0, "half clock idle before sync")
		`CHK(nrz_data, 1'b0, "nrz low before sync")
		tag(10'h080);
		repeat (SYNC_ZEROS) code_bit(1'b0);
		`CHK(half_rate_clk, 1'b0, "no sync on zeros alone")
		code_bit(1'b1);
		`CHK(half_rate_clk, 1'b1, "sync on zeros then one")
		tag(10'h100);
		code_bit(1'b0);
		`CHK(half_rate_clk, 1'b0, "half clock toggles")
		code_bit(1'b0);
		`CHK(half_rate_clk, 1'b1, "half clock toggles again")
	endtask : t_sync

	// Runs on from the sync pattern: every 2,7 word once, then a flush word
	task t_decode();
		logic [41:0] code;
		logic [21:0] nrz_exp;
		code    = 42'h104_9082_4084;
		nrz_exp = 22'h1c_1323;
		code_bit(1'b0);
		`CHK(nrz_data, nrz_exp[21], "nrz held during lag")
		for (int i = 0; i < 21; i++)
		begin
			code_bit(code[41 - 2 * i]);
			code_bit(code[40 - 2 * i]);
			`CHK(nrz_data, nrz_exp[20 - i], "nrz decoded bit")
		end
	endtask : t_decode

	task t_mark();
		int n;
		tag(10'h022);
		pulse(3);
		repeat (25) pulse(2);
		rd_pulse = 1'b1;
		n = 0;
		while (mark_found !== 1'b1 && n < 4)
		begin
			cyc(1);
			n++;
		end
		`CHK(mark_found, 1'b1, "mark after long gap")
		`CHK(address_mark_status, 1'b0, "status one cycle later")
		cyc(1);
		`CHK(address_mark_status, 1'b1, "status follows mark")
		rd_pulse = 1'b0;
		cyc(10);
		`CHK(mark_found, 1'b1, "mark held")
		gate_req = 1'b0;
		cyc(5);
		`CHK(mark_found, 1'b0, "mark cleared by gate low")
		gap(25);
		`CHK(mark_found, 1'b0, "no search without gate")
		gate_req = 1'b1;
		cyc(4);
		gap(AM_MAX + 6);
		cyc(2);
		`CHK(mark_found, 1'b0, "defect gap flags no mark")
		gap(25);
		`CHK(mark_found, 1'b1, "mark after second gap")
		tag(10'h000);
		`CHK(mark_found, 1'b1, "mark held while lock stands")
		n = 0;
		while (data_lock_window === 1'b1 && n < 600)
		begin
			cyc(1);
			n++;
		end
		`CHK(n inside {[LOCK_CYC - 6:LOCK_CYC + 6]}, 1'b1, "lock ends after search")
		`CHK(mark_found, 1'b0, "mark cleared at lock end")
	endtask : t_mark

	initial
	begin
		fails = 0;
		compares = 0;
		cycles = 0;
		rst_n = 1'b0;
		{tag_valid, gate_req, rd_pulse, wr_ref, wr_half, rd_osc, rd_data} = 7'h00;
		tag_bus = 10'h000;
		cyc(6);
		`CHK(data_lock_window, 1'b1, "lock window set in reset")
		`CHK({pump_up, pump_down, osc_hold_window, mark_found}, 4'h0, "reset outputs")
		rst_n = 1'b1;
		cyc(4);
		t_coinc();
		t_lock_hold();
		t_quad();
		t_sync();
		t_decode();
		t_mark();
		results();
	end
endmodule : tb
